/* File: rtl/sar_conv_ctrl.sv */
// Power-down and short-cycle sequencer of a 16-bit SAR converter
`include "sar_cfg.svh"
module sar_conv_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic serial_bit_clock,
  input wire logic [15:0] sample_code,
  output logic data_out,
  output logic data_out_en,
  output logic analog_power_on,
  output logic digital_power_on
);
  sar_pkg::conv_regs_t cur;
  sar_pkg::conv_regs_t next_cur;
  logic cs_s;
  logic sclk_s;
  logic sclk_fall;
  logic cs_fall;
  logic analog_busy;

  // Pin synchronisers
  sync2 #(.INIT(1'b1)) u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(chip_sel_n),
    .level(cs_s)
  );
  sync2 #(.INIT(1'b0)) u_sclk_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(serial_bit_clock),
    .level(sclk_s)
  );

  // Edge detection on synchronised levels
  assign sclk_fall = cur.sclk_prev & ~sclk_s;
  assign cs_fall = cur.cs_prev & ~cs_s;

  // Sequencer and power control
  always_comb begin
    next_cur = cur;
    next_cur.sclk_prev = sclk_s;
    next_cur.cs_prev = cs_s;
    if (cs_s) begin
      // Abort or idle: release pin, reset sequencing
      next_cur.dout_en = 1'b0;
      next_cur.dout = 1'b0;
      next_cur.idx = `SAR_LSB_IDX;
      if (cur.state != sar_pkg::ST_PWRUP) begin
        next_cur.state = sar_pkg::ST_IDLE;
      end
    end else if (cs_fall) begin
      next_cur.state = sar_pkg::ST_SAMPLE;
      next_cur.idx = `SAR_LSB_IDX;
    end else if (sclk_fall) begin
      case (cur.state)
        sar_pkg::ST_SAMPLE: begin
          if (cur.idx == `SAR_SAMPLE_LAST_IDX) begin
            next_cur.state = sar_pkg::ST_LEAD;
            next_cur.dout_en = 1'b1;
            next_cur.dout = 1'b0;
            next_cur.code = sample_code;
          end else begin
            next_cur.idx = cur.idx + 4'h1;
          end
        end
        sar_pkg::ST_LEAD: begin
          next_cur.state = sar_pkg::ST_MSBF;
          next_cur.idx = `SAR_MSB_IDX;
          next_cur.dout = cur.code[`SAR_MSB_IDX];
        end
        sar_pkg::ST_MSBF: begin
          if (cur.idx == `SAR_LSB_IDX) begin
            next_cur.state = sar_pkg::ST_LSBF;
            next_cur.idx = `SAR_FIRST_RESEND_IDX;
            next_cur.dout = cur.code[`SAR_FIRST_RESEND_IDX];
          end else begin
            next_cur.idx = cur.idx - 4'h1;
            next_cur.dout = cur.code[cur.idx - 4'h1];
          end
        end
        sar_pkg::ST_LSBF: begin
          if (cur.idx == `SAR_MSB_IDX) begin
            next_cur.state = sar_pkg::ST_DONE;
            next_cur.dout_en = 1'b0;
            next_cur.dout = 1'b0;
          end else begin
            next_cur.idx = cur.idx + 4'h1;
            next_cur.dout = cur.code[cur.idx + 4'h1];
          end
        end
        default: begin
          next_cur.state = cur.state; // Done state ignores clocks
        end
      endcase
    end
    // Analog stays up from start until result is complete
    case (next_cur.state)
      sar_pkg::ST_PWRUP,
      sar_pkg::ST_SAMPLE,
      sar_pkg::ST_LEAD,
      sar_pkg::ST_MSBF: analog_busy = 1'b1;
      default: analog_busy = 1'b0;
    endcase
    next_cur.pwr_analog = analog_busy;
    next_cur.pwr_digital = ~cs_s;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '{state: sar_pkg::ST_PWRUP, idx: 4'h0, code: 16'h0000,
               dout: 1'b0, dout_en: 1'b0, pwr_analog: 1'b1,
               pwr_digital: 1'b1, sclk_prev: 1'b0, cs_prev: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign data_out = cur.dout;
  assign data_out_en = cur.dout_en;
  assign analog_power_on = cur.pwr_analog;
  assign digital_power_on = cur.pwr_digital;

  // Checks
  sequence fifth_fall_s;
    cur.state == sar_pkg::ST_SAMPLE && sclk_fall && !cs_s &&
      cur.idx == 4'h4;
  endsequence
  sequence msb_step_s;
    cur.state == sar_pkg::ST_MSBF && sclk_fall && !cs_s && cur.idx != 4'h0;
  endsequence
  sequence last_resend_s;
    cur.state == sar_pkg::ST_LSBF && sclk_fall && !cs_s && cur.idx == 4'hF;
  endsequence
  sequence lsb_step_s;
    cur.state == sar_pkg::ST_LSBF && sclk_fall && !cs_s &&
      cur.idx != `SAR_MSB_IDX;
  endsequence

  lead_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifth_fall_s |=> data_out_en && !data_out && cur.state == sar_pkg::ST_LEAD)
    else $error("Lead-in low bit missing after fifth fall");
  msb_first_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_LEAD && sclk_fall && !cs_s) |=>
      data_out == cur.code[15] && data_out_en)
    else $error("First result bit is not the MSB");
  bit_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    msb_step_s |=> cur.idx == $past(cur.idx) - 4'h1 &&
      data_out == cur.code[cur.idx])
    else $error("Result bit not advanced by one per fall");
  abort_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cs_s && cur.state != sar_pkg::ST_PWRUP) |=>
      !data_out_en && cur.state == sar_pkg::ST_IDLE && cur.idx == 4'h0)
    else $error("Select high did not abort and release");
  digital_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    cs_s |=> !digital_power_on)
    else $error("Digital section on with select high");
  analog_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_SAMPLE || cur.state == sar_pkg::ST_MSBF)
      |-> analog_power_on)
    else $error("Analog section off during conversion");
  done_park_a: assert property (@(posedge clk) disable iff (sys_rst)
    last_resend_s |=> (!data_out_en && !analog_power_on &&
      cur.state == sar_pkg::ST_DONE) ##1 (!data_out_en &&
      !analog_power_on && (cur.state == sar_pkg::ST_DONE || $past(cs_s))))
    else $error("Output not released or analog not down at end");
  no_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_DONE && !cs_s) |=>
      cur.state == sar_pkg::ST_DONE)
    else $error("Conversion restarted without select high");
  start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cs_fall && !cs_s) |=> cur.state == sar_pkg::ST_SAMPLE ##1
      (analog_power_on || $past(cs_s)))
    else $error("Select fall did not start sampling");

  // Sampling phase counts five falls before the lead bit
  sample_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_SAMPLE && sclk_fall && !cs_s &&
      cur.idx != `SAR_SAMPLE_LAST_IDX) |=>
      cur.state == sar_pkg::ST_SAMPLE && !data_out_en &&
      cur.idx == $past(cur.idx) + 4'h1)
    else $error("Sampling phase did not count one fall");
  code_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifth_fall_s |=> cur.code == $past(sample_code))
    else $error("Result code not taken at fifth fall");

  // Result tail: resend order, analog shut-off and ignored clocks
  analog_down_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_MSBF && sclk_fall && !cs_s &&
      cur.idx == `SAR_LSB_IDX) |=> !analog_power_on &&
      cur.state == sar_pkg::ST_LSBF &&
      data_out == cur.code[`SAR_FIRST_RESEND_IDX])
    else $error("Analog not down or resend not started after LSB");
  lsb_resend_a: assert property (@(posedge clk) disable iff (sys_rst)
    lsb_step_s |=> data_out_en && cur.idx == $past(cur.idx) + 4'h1 &&
      data_out == cur.code[cur.idx])
    else $error("Resent bit not advanced LSB first");
  done_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_DONE && sclk_fall && !cs_s) |=>
      !data_out_en && !analog_power_on)
    else $error("Clock after the end drove the output");

  // Power state while select low and after power-up
  digital_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cs_s |=> digital_power_on)
    else $error("Digital section off with select low");
  pwrup_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.state == sar_pkg::ST_PWRUP && cs_s) |=>
      cur.state == sar_pkg::ST_PWRUP && analog_power_on)
    else $error("Power-up bias state left before a conversion");
endmodule

/* File: common/sar_cfg.svh */
// Constants for the converter power and short-cycle sequencer
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_RESULT_BITS 16
`define SAR_IDX_W 4
`define SAR_SAMPLE_LAST_IDX 4'h4
`define SAR_MSB_IDX 4'hF
`define SAR_LSB_IDX 4'h0
`define SAR_FIRST_RESEND_IDX 4'h1
`define SAR_CLK_NS 100
`define SAR_BIT_DECISION_NS 167
`define SAR_BIT_DECISION_CYC ((`SAR_BIT_DECISION_NS) / (`SAR_CLK_NS))
`endif

/* File: common/sar_pkg.sv */
// Types for the converter power and short-cycle sequencer
package sar_pkg;
  typedef enum logic [6:0] {
    ST_PWRUP = 7'h01,
    ST_IDLE = 7'h02,
    ST_SAMPLE = 7'h04,
    ST_LEAD = 7'h08,
    ST_MSBF = 7'h10,
    ST_LSBF = 7'h20,
    ST_DONE = 7'h40
  } conv_state_t;

  typedef struct packed {
    conv_state_t state;
    logic [3:0] idx;
    logic [15:0] code;
    logic dout;
    logic dout_en;
    logic pwr_analog;
    logic pwr_digital;
    logic sclk_prev;
    logic cs_prev;
  } conv_regs_t;
endpackage

/* File: rtl/sync2.sv */
// Two-stage synchroniser for one pin level
module sync2 #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level
);
  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= INIT;
      level <= INIT;
    end else begin
      stage1 <= pin;
      level <= stage1;
    end
  end
endmodule

/* File: tb/sar_host.sv */
// Host model that drives select and the serial bit clock
module sar_host (
  input wire logic clk,
  output logic chip_sel_n,
  output logic serial_bit_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // Select high and clock parked low outside frames
  initial begin
    chip_sel_n = 1'b1;
    serial_bit_clock = 1'b0;
  end
  // Lower select and give n bit clock periods of 800 ns
  task automatic frame(input int n);
    @(negedge clk) chip_sel_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      serial_bit_clock = 1'b1;
      repeat (4) @(negedge clk);
      serial_bit_clock = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  // Raise select, which ends or aborts the frame
  task automatic release_sel();
    chip_sel_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* File: tb/sar_conv_ctrl_bench.sv */
// Self-checking bench for the converter sequencer
module sar_conv_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_sel_n;
  logic serial_bit_clock;
  logic [15:0] sample_code = 16'h0000;
  logic data_out;
  logic data_out_en;
  logic analog_power_on;
  logic digital_power_on;
  logic exp_q[$];
  int bad_count = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  sar_host u_host (.clk(clk), .chip_sel_n(chip_sel_n),
    .serial_bit_clock(serial_bit_clock));
  sar_conv_ctrl uut (.clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
    .serial_bit_clock(serial_bit_clock), .sample_code(sample_code),
    .data_out(data_out), .data_out_en(data_out_en),
    .analog_power_on(analog_power_on), .digital_power_on(digital_power_on));
  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Host samples on the rising bit clock; take the oldest note
  always @(posedge serial_bit_clock) begin
    if (data_out_en === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check(data_out, exp_q.pop_front());
    end
  end
  // One conversion; short keeps the lead bit and 14 result bits
  task automatic conv(input bit short);
    sample_code = 16'($urandom());
    exp_q.push_back(1'b0);
    for (int i = 15; i >= (short ? 2 : 0); i--) exp_q.push_back(sample_code[i]);
    if (!short) for (int i = 1; i < 16; i++) exp_q.push_back(sample_code[i]);
    fork
      u_host.frame(short ? 20 : 38);
      begin
        repeat (60) @(negedge clk);
        check(analog_power_on, 16'h0001);
      end
    join
    if (!short) begin
      check(analog_power_on, 16'h0000);
      check(digital_power_on, 16'h0001);
      check(data_out_en, 16'h0000);
    end
    u_host.release_sel();
    check(data_out_en, 16'h0000);
    check(analog_power_on, 16'h0000);
    check(digital_power_on, 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    exp_q.delete();
    $display("Test done: short %0d checks %0d", short, num_checks);
  endtask
  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then full, short, full and short conversions
  initial begin
    void'($urandom(6));
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(analog_power_on, 16'h0001);
    check(digital_power_on, 16'h0000);
    check(data_out_en, 16'h0000);
    conv(1'b0);
    conv(1'b1);
    conv(1'b0);
    conv(1'b1);
    conclude();
  end
endmodule
